// ===== hw/reset_cause_bank.sv
// Mode-3 part-3 configuration and reset cause registers of the power manager.
`timescale 1ns/10ps
// Summary of operation
// - Watchdog code selects off, 16, 32, 64 s
// - Offset bit adds 1.2 V to voltage
// - Code maps 1.5 V plus 25 mV, capped 2.1
// - Config register read/write, resets to 00,0,01100
// - Host reads reset cause register at 0x71
// - Bit 7 filtered key, low after 5 ms
// - Bit 4 thermal exit flag, write 1 clears
// - Bit 3 ship exit flag survives ship cycle
// - Ship cycle clears bits 4, 2, 1, 0; bit 7 resets high
// - Bit 2 soft reset flag, write 1 clears
// - Bit 1 watchdog reset, config kept, w1c
// - Bit 0 long press flag, write 1 clears
module reset_cause_bank #(
	parameter int debounce_count = pmic_regs_pkg::debounce_cycles
) (
	input  wire logic                      clock,
	input  wire logic                      nrst,
	input  wire logic                      ship_nrst,
	input  wire logic                      defaults_load,
	input  wire pmic_regs_pkg::reg_req_t   req,
	input  wire pmic_regs_pkg::cause_evt_t evt,
	input  wire logic                      key_pin,
	output logic [7:0]                     rdata,
	output logic                           rvalid,
	output logic [6:0]                     watchdog_seconds,
	output logic                           watchdog_enable,
	output logic [11:0]                    regulator_mv
);
	import pmic_regs_pkg::*;

	logic [1:0]  watchdog_period_mode3_reg;
	logic        aux_regulator_offset_mode3_reg;
	logic [4:0]  aux_regulator_code_mode3_reg;
	logic        thermal_exit_flag_reg;
	logic        ship_exit_flag_reg;
	logic        soft_reset_flag_reg;
	logic        watchdog_reset_flag_reg;
	logic        long_press_flag_reg;
	logic        key_level_filtered_reg;
	logic [2:0]  key_sync_reg;
	logic [31:0] debounce_cnt_reg;
	logic [7:0]  cause_view;
	logic        cause_write;
	logic        cfg_write;

	// Voltage in millivolts for a code and offset, with the top codes capped.
	function automatic logic [11:0] code_to_mv(input logic [4:0] code, input logic offs);
		logic [4:0]  capped;
		logic [11:0] mv;
		capped = (code > code_max) ? code_max : code;
		mv = base_mv + 12'(capped) * step_mv;
		return offs ? 12'(mv + offset_mv) : mv;
	endfunction

	assign cfg_write   = req.wr && (req.addr == mode3_part3_config_addr);
	assign cause_write = req.wr && (req.addr == reset_cause_monitor_addr);

	// ------------------------------------------------------------
	// Configuration register
	// ------------------------------------------------------------
	// A software, thermal or long-press reset reloads defaults; watchdog resets keep them.
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			watchdog_period_mode3_reg      <= wd_period_reset;
			aux_regulator_offset_mode3_reg <= offset_reset;
			aux_regulator_code_mode3_reg   <= code_reset;
		end else if (defaults_load) begin
			watchdog_period_mode3_reg      <= wd_period_reset;
			aux_regulator_offset_mode3_reg <= offset_reset;
			aux_regulator_code_mode3_reg   <= code_reset;
		end else if (cfg_write) begin
			watchdog_period_mode3_reg      <= req.wdata[wd_field_lsb +: 2];
			aux_regulator_offset_mode3_reg <= req.wdata[offset_bit_pos];
			aux_regulator_code_mode3_reg   <= req.wdata[4:0];
		end
	end

	// Decoded watchdog period and regulator setpoint.
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			watchdog_seconds <= 7'h00;
			watchdog_enable  <= 1'b0;
			regulator_mv     <= 12'h000;
		end else begin
			case (watchdog_period_mode3_reg)
				wd_16s:  watchdog_seconds <= wd_16s_seconds;
				wd_32s:  watchdog_seconds <= wd_32s_seconds;
				wd_64s:  watchdog_seconds <= wd_64s_seconds;
				default: watchdog_seconds <= 7'h00;
			endcase
			watchdog_enable <= (watchdog_period_mode3_reg != wd_off);
			regulator_mv <= code_to_mv(aux_regulator_code_mode3_reg,
				aux_regulator_offset_mode3_reg);
		end
	end

	// ------------------------------------------------------------
	// Reset cause flags
	// ------------------------------------------------------------
	// Core-domain flags; nrst is the core power cycle, so ship cycles clear them.
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			thermal_exit_flag_reg   <= 1'b0;
			soft_reset_flag_reg     <= 1'b0;
			watchdog_reset_flag_reg <= 1'b0;
			long_press_flag_reg     <= 1'b0;
		end else begin
			// A set in the same cycle as a write-one clear wins.
			thermal_exit_flag_reg <= evt.thermal_exit | (thermal_exit_flag_reg &
				~(cause_write & req.wdata[thermal_bit_pos]));
			soft_reset_flag_reg <= evt.soft_reset | (soft_reset_flag_reg &
				~(cause_write & req.wdata[soft_bit_pos]));
			watchdog_reset_flag_reg <= evt.watchdog_reset | (watchdog_reset_flag_reg &
				~(cause_write & req.wdata[watchdog_bit_pos]));
			long_press_flag_reg <= evt.long_press | (long_press_flag_reg &
				~(cause_write & req.wdata[long_press_bit_pos]));
		end
	end

	// Ship exit flag lives on the always-on reset so it survives the ship cycle.
	always_ff @(posedge clock or negedge ship_nrst) begin
		if (!ship_nrst) begin
			ship_exit_flag_reg <= 1'b0;
		end else begin
			ship_exit_flag_reg <= evt.ship_exit | (ship_exit_flag_reg &
				~(cause_write & req.wdata[ship_bit_pos]));
		end
	end

	// ------------------------------------------------------------
	// Power key debounce
	// ------------------------------------------------------------
	// Three-stage synchroniser; stage one feeds only stage two.
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			key_sync_reg <= 3'h7;
		end else begin
			key_sync_reg <= {key_sync_reg[1:0], key_pin};
		end
	end

	// High passes at once; low must hold for the full debounce time.
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			key_level_filtered_reg <= 1'b1;
			debounce_cnt_reg       <= 32'h0;
		end else if (key_sync_reg[2] & key_sync_reg[1]) begin
			key_level_filtered_reg <= 1'b1;
			debounce_cnt_reg       <= 32'h0;
		end else if (!key_sync_reg[2] && !key_sync_reg[1]) begin
			if (debounce_cnt_reg >= 32'(debounce_count - 1)) begin
				key_level_filtered_reg <= 1'b0;
			end else begin
				debounce_cnt_reg <= debounce_cnt_reg + 32'h1;
			end
		end
	end

	// ------------------------------------------------------------
	// Register read port
	// ------------------------------------------------------------
	// Reserved bits 6 and 5 read zero.
	assign cause_view = {key_level_filtered_reg, 2'b00, thermal_exit_flag_reg,
		ship_exit_flag_reg, soft_reset_flag_reg, watchdog_reset_flag_reg,
		long_press_flag_reg};

	// Read data is registered one cycle after the request.
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			rdata  <= 8'h00;
			rvalid <= 1'b0;
		end else begin
			rvalid <= req.rd;
			if (!req.rd) begin
				rdata <= 8'h00;
			end else if (req.addr == mode3_part3_config_addr) begin
				rdata <= {watchdog_period_mode3_reg, aux_regulator_offset_mode3_reg,
					aux_regulator_code_mode3_reg};
			end else if (req.addr == reset_cause_monitor_addr) begin
				rdata <= cause_view;
			end else begin
				rdata <= 8'h00;
			end
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	chk_flag_set_wins: assert property (@(posedge clock) disable iff (!nrst)
		evt.thermal_exit |=> thermal_exit_flag_reg)
		else $error("thermal exit flag not set");
	chk_zero_write_keeps: assert property (@(posedge clock) disable iff (!nrst)
		(cause_write && !req.wdata[soft_bit_pos] && soft_reset_flag_reg) |=>
		soft_reset_flag_reg)
		else $error("soft reset flag lost on zero write");
	chk_one_write_clears: assert property (@(posedge clock) disable iff (!nrst)
		(cause_write && req.wdata[long_press_bit_pos] && !evt.long_press) |=>
		!long_press_flag_reg)
		else $error("long press flag not cleared");
	chk_wd_flag_clear: assert property (@(posedge clock) disable iff (!nrst)
		(cause_write && req.wdata[watchdog_bit_pos] && !evt.watchdog_reset) |=>
		!watchdog_reset_flag_reg)
		else $error("watchdog flag not cleared");
	chk_ship_flag_set: assert property (@(posedge clock) disable iff (!ship_nrst)
		evt.ship_exit |=> ship_exit_flag_reg)
		else $error("ship exit flag not set");
	chk_key_high_fast: assert property (@(posedge clock) disable iff (!nrst)
		(key_sync_reg[2] && key_sync_reg[1]) |=> key_level_filtered_reg)
		else $error("key high not passed at once");
	chk_key_low_wait: assert property (@(posedge clock) disable iff (!nrst)
		$fell(key_level_filtered_reg) |-> debounce_cnt_reg == 32'(debounce_count - 1))
		else $error("key low reported early");
	chk_wd_decode: assert property (@(posedge clock) disable iff (!nrst)
		(watchdog_period_mode3_reg == wd_32s) |=> watchdog_seconds == wd_32s_seconds)
		else $error("watchdog period decode wrong");
	chk_cfg_default: assert property (@(posedge clock) disable iff (!nrst)
		defaults_load |=> aux_regulator_code_mode3_reg == code_reset)
		else $error("config default not restored");
	chk_voltage_cap: assert property (@(posedge clock) disable iff (!nrst)
		(aux_regulator_code_mode3_reg > code_max && !aux_regulator_offset_mode3_reg) |=>
		regulator_mv == 12'h834)
		else $error("voltage cap wrong");
	chk_read_cause: assert property (@(posedge clock) disable iff (!nrst)
		(req.rd && req.addr == reset_cause_monitor_addr) |=> rvalid && rdata[6:5] == 2'b00)
		else $error("cause read wrong");

endmodule // reset_cause_bank

// ===== common/pmic_regs_pkg.sv
// Package with offsets, field layouts, reset values and timing counts of the register bank.
package pmic_regs_pkg;

	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] mode3_part3_config_addr  = 8'h31;
	localparam logic [7:0] reset_cause_monitor_addr = 8'h71;

	// ------------------------------------------------------------
	// Field layout and reset values
	// ------------------------------------------------------------
	localparam int         wd_field_lsb        = 6;
	localparam int         offset_bit_pos      = 5;
	localparam logic [1:0] wd_period_reset     = 2'h0;
	localparam logic       offset_reset        = 1'b0;
	localparam logic [4:0] code_reset          = 5'h0c;
	localparam int         key_bit_pos         = 7;
	localparam int         thermal_bit_pos     = 4;
	localparam int         ship_bit_pos        = 3;
	localparam int         soft_bit_pos        = 2;
	localparam int         watchdog_bit_pos    = 1;
	localparam int         long_press_bit_pos  = 0;

	// ------------------------------------------------------------
	// Watchdog period decode and voltage figures (millivolts)
	// ------------------------------------------------------------
	localparam logic [1:0] wd_off              = 2'h0;
	localparam logic [1:0] wd_16s              = 2'h1;
	localparam logic [1:0] wd_32s              = 2'h2;
	localparam logic [1:0] wd_64s              = 2'h3;
	localparam logic [6:0] wd_16s_seconds      = 7'h10;
	localparam logic [6:0] wd_32s_seconds      = 7'h20;
	localparam logic [6:0] wd_64s_seconds      = 7'h40;
	localparam logic [11:0] base_mv            = 12'h5dc;
	localparam logic [11:0] step_mv            = 12'h019;
	localparam logic [11:0] offset_mv          = 12'h4b0;
	localparam logic [4:0] code_max            = 5'h18;

	// ------------------------------------------------------------
	// Debounce timing
	// ------------------------------------------------------------
	localparam int         clock_mhz           = 125;
	localparam int         debounce_ms         = 5;
	localparam int         debounce_cycles     = debounce_ms * 1000 * clock_mhz;

	// Host register access carrier.
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_t;

	// Reset cause events, one-cycle pulses from the supervisor.
	typedef struct packed {
		logic thermal_exit;
		logic ship_exit;
		logic soft_reset;
		logic watchdog_reset;
		logic long_press;
	} cause_evt_t;

endpackage

// ===== testbench/host_model.sv
// Host model that drives the register strobe port of the bank.
`timescale 1ns/10ps
module host_model (
	input  wire logic                  clock,
	input  wire logic [7:0]            rdata,
	input  wire logic                  rvalid,
	output pmic_regs_pkg::reg_req_t    req
);
	import pmic_regs_pkg::*;

	// The idle bus starts low, with both strobes off.
	initial begin
		req = '0;
	end

	// One access holds its strobe over a single taken edge and takes the answer after it.
	task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] wdata,
		output logic [7:0] got);
		@(posedge clock);
		#1;
		req = '{wr: wr, rd: !wr, addr: addr, wdata: wdata};
		@(posedge clock);
		#1;
		got = rvalid ? rdata : 8'hxx;
		// Released fields show inverted leftovers, so stale data is never mistaken for real.
		req = '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~wdata};
	endtask
endmodule // host_model

// ===== testbench/tb_reset_cause_bank.sv
// Self-checking testbench of the mode-3 configuration and reset cause bank.
`timescale 1ns/10ps
module tb_reset_cause_bank;
	import pmic_regs_pkg::*;
	localparam int deb = 8;
	logic        clock, nrst, ship_nrst, defaults_load, key_pin, rvalid, watchdog_enable;
	reg_req_t    req;
	cause_evt_t  evt;
	logic [7:0]  rdata, got;
	logic [6:0]  watchdog_seconds;
	logic [11:0] regulator_mv;
	int          bad_count = 0;
	int          compares = 0;
	int          cfg, flags;

	reset_cause_bank #(.debounce_count(deb)) reset_cause_bank_inst (.clock(clock), .nrst(nrst),
		.ship_nrst(ship_nrst), .defaults_load(defaults_load), .req(req), .evt(evt),
		.key_pin(key_pin), .rdata(rdata), .rvalid(rvalid), .watchdog_seconds(watchdog_seconds),
		.watchdog_enable(watchdog_enable), .regulator_mv(regulator_mv));
	host_model host_model_inst (.clock(clock), .rdata(rdata), .rvalid(rvalid), .req(req));

	// ------------------------------------------------------------
	// Compare and access tasks
	// ------------------------------------------------------------
	task automatic report_and_stop();
		if (bad_count == 0 && compares > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
		compares++;
		if (g !== e) begin
			$display("mismatch %0t read %h expected %h", $time, g, e);
			bad_count++;
		end
	endtask
	// Expected setpoints come from the integer model of the configuration byte.
	task automatic chk_outs();
		int code;
		int mv;
		code = (cfg & 31) > 24 ? 24 : (cfg & 31);
		mv = 1500 + 25 * code + ((cfg >> 5) & 1) * 1200;
		compares++;
		if (regulator_mv !== 12'(mv) || watchdog_enable !== ((cfg >> 6) != 0)
			|| watchdog_seconds !== 7'((cfg >> 6) == 0 ? 0 : 8 << (cfg >> 6))) begin
			$display("mismatch %0t outputs for config %h", $time, cfg);
			bad_count++;
		end
	endtask
	task automatic rd_chk(input logic [7:0] a, input int e);
		host_model_inst.access(1'b0, a, 8'h00, got);
		chk_byte(got, 8'(e));
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		host_model_inst.access(1'b1, a, d, got);
	endtask
	task automatic pulse_evt(input logic [4:0] m);
		@(posedge clock);
		#1 evt = m;
		@(posedge clock);
		#1 evt = '0;
		flags = flags | m;
	endtask

	// The clock toggles every 4 ns, half of its 8 ns period.
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	// A hang is cut short well beyond the expected run length.
	initial begin
		#200000;
		bad_count++;
		report_and_stop();
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		logic [7:0] v;
		nrst = 0; ship_nrst = 0; defaults_load = 0; evt = '0; key_pin = 1;
		cfg = 8'h0c; flags = 8'h80;
		void'($urandom(90398));
		repeat (12) @(posedge clock);
		#1 nrst = 1;
		ship_nrst = 1;
		rd_chk(8'h31, cfg);
		rd_chk(8'h71, flags);
		rd_chk(8'h55, 8'h00);
		chk_outs();
		for (int i = 0; i < 12; i++) begin
			v = 8'($urandom);
			if (i < 4) v = {2'(i), i[0], 5'h18 + 5'(i)};
			wr(8'h31, v);
			cfg = v;
			repeat (3) @(posedge clock);
			rd_chk(8'h31, cfg);
			chk_outs();
		end
		wr(8'h30, 8'hff);
		rd_chk(8'h31, cfg);
		for (int i = 0; i < 5; i++) begin
			pulse_evt(5'(1 << i));
			rd_chk(8'h71, flags);
		end
		wr(8'h71, 8'he0);
		rd_chk(8'h71, flags);
		rd_chk(8'h31, cfg);
		for (int i = 0; i < 5; i++) begin
			wr(8'h71, 8'(1 << i));
			flags = flags & ~(1 << i);
			rd_chk(8'h71, flags);
		end
		// A thermal event in the very cycle of its write-one clear must leave the flag set.
		fork
			pulse_evt(5'h10);
			wr(8'h71, 8'h10);
		join
		rd_chk(8'h71, flags);
		pulse_evt(5'h1f);
		#1 defaults_load = 1;
		@(posedge clock);
		#1 defaults_load = 0;
		cfg = 8'h0c;
		rd_chk(8'h31, cfg);
		@(posedge clock);
		#1 nrst = 0;
		@(posedge clock);
		#1 nrst = 1;
		flags = flags & 8'h88;
		rd_chk(8'h71, flags);
		@(posedge clock);
		#1 ship_nrst = 0;
		@(posedge clock);
		#1 ship_nrst = 1;
		flags = 8'h80;
		rd_chk(8'h71, flags);
		// A low pulse shorter than the debounce time must never reach bit 7.
		key_pin = 0;
		repeat (deb - 2) @(posedge clock);
		#1 key_pin = 1;
		repeat (4) @(posedge clock);
		rd_chk(8'h71, 8'h80);
		// A held low reaches bit 7 exactly after three sync stages and the full count.
		key_pin = 0;
		repeat (deb + 1) @(posedge clock);
		rd_chk(8'h71, 8'h80);
		rd_chk(8'h71, 8'h00);
		#1 key_pin = 1;
		repeat (4) @(posedge clock);
		rd_chk(8'h71, 8'h80);
		report_and_stop();
	end
endmodule // tb_reset_cause_bank
